// *** common/wdog_consts.vh ***
// Register map, field layout and timing counts of the windowed watchdog
`ifndef WDOG_CONSTS_VH
`define WDOG_CONSTS_VH
// Register byte offsets
`define OFF_SERVICE 8'h00
`define OFF_CONTROL 8'h04
`define OFF_STATUS 8'h08
`define OFF_IDLE_TIMER 8'h0C
// Service register fields
`define SVC_WIN_HI 7
`define SVC_WIN_LO 6
`define SVC_KEY_HI 5
`define SVC_KEY_LO 1
`define SVC_CM_BIT 0
`define SVC_KEY 5'h0C
`define SVC_WIN_RESET 2'h3
`define SVC_CM_RESET 1'b1
// Control and status fields
`define CTL_CLOCK_DELAY_BIT 0
`define STS_PEND_BIT 0
`define STS_ACTIVE_BIT 1
`define STS_CMERR_BIT 2
`define STS_CONFIG_BIT 3
// Timing in instruction cycles
`define LOWER_LIMIT_TC 16'h0800
`define UPPER_BASE_TC 17'h0_2000
`define PIN_HOLD_TC 5'h10
`define IDLE_PEND_BIT 12
// Clocks per instruction cycle
`define CYCLE_DIV 10
// Clock monitor reject time in ns, and clock period in ns
`define CM_LIMIT_NS 1000000
`define CLK_PERIOD_NS 40
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** verilog/axil_reg_port.v ***
// AXI4-Lite slave front end producing a register write strobe and a read address
`timescale 1ns/1ps
`default_nettype none
`include "wdog_consts.vh"
module axil_reg_port (
	input wire clk_in,
	input wire sys_rst_in,
	input wire [7:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output reg s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output reg s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [7:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output reg s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	output reg wr_pulse_out,
	output reg [7:0] wr_addr_out,
	output reg [7:0] wr_data_out,
	output wire [7:0] rd_addr_out,
	input wire [31:0] rd_data_in
);
	reg aw_held_reg;
	reg w_held_reg;
	reg ar_held_reg;
	reg [7:0] aw_addr_reg;
	reg [7:0] ar_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;

	// Word offsets that hold a register
	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = (a == `OFF_SERVICE) || (a == `OFF_CONTROL) ||
				(a == `OFF_STATUS) || (a == `OFF_IDLE_TIMER);
		end
	endfunction

	assign rd_addr_out = ar_addr_reg;

	// Write channel: address and data in either order
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `RESP_OKAY;
			wr_pulse_out <= 1'b0;
			wr_addr_out <= 8'h00;
			wr_data_out <= 8'h00;
		end else begin
			wr_pulse_out <= 1'b0;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_in;
				w_strb_reg <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (aw_held_reg && w_held_reg && !s_axi_bvalid_out) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= addr_ok(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
				wr_pulse_out <= addr_ok(aw_addr_reg) && w_strb_reg[0];
				wr_addr_out <= aw_addr_reg;
				wr_data_out <= w_data_reg[7:0];
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	// Read channel: one cycle to fetch the word
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			ar_held_reg <= 1'b0;
			ar_addr_reg <= 8'h00;
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				ar_held_reg <= 1'b1;
				ar_addr_reg <= s_axi_araddr_in;
				s_axi_arready_out <= 1'b0;
			end
			if (ar_held_reg) begin
				ar_held_reg <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= addr_ok(ar_addr_reg) ? rd_data_in : 32'h0000_0000;
				s_axi_rresp_out <= addr_ok(ar_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
				s_axi_arready_out <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/clk_freq_monitor.v ***
// Clock monitor flagging missing or slow instruction-cycle ticks
`timescale 1ns/1ps
`default_nettype none
`include "wdog_consts.vh"
module clk_freq_monitor #(
	parameter LIMIT_CLKS = `CM_LIMIT_NS / `CLK_PERIOD_NS
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire enable_in,
	input wire tick_in,
	output reg err_out
);
	reg [31:0] gap_reg;

	// Gap between ticks; too long a gap is a frequency error
	always @(posedge clk_in) begin
		if (sys_rst_in || !enable_in) begin
			gap_reg <= 32'h0000_0000;
			err_out <= 1'b0;
		end else if (tick_in) begin
			gap_reg <= 32'h0000_0000;
			err_out <= 1'b0; // Clock has recovered
		end else if (gap_reg >= LIMIT_CLKS - 1) begin
			err_out <= 1'b1;
		end else begin
			gap_reg <= gap_reg + 32'h0000_0001;
		end
	end
endmodule
`default_nettype wire

// *** verilog/windowed_watchdog_clock_monitor.v ***
// Windowed watchdog with clock monitor and idle timer, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "wdog_consts.vh"
module windowed_watchdog_clock_monitor #(
	parameter CYCLE_DIV = `CYCLE_DIV,
	parameter CM_LIMIT_CLKS = `CM_LIMIT_NS / `CLK_PERIOD_NS
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire [7:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output wire s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output wire s_axi_wready_out,
	output wire [1:0] s_axi_bresp_out,
	output wire s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [7:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output wire s_axi_arready_out,
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0] s_axi_rresp_out,
	output wire s_axi_rvalid_out,
	input wire s_axi_rready_in,
	input wire osc_ok_in,
	input wire halt_in,
	input wire idle_in,
	input wire rc_osc_option_in,
	input wire timeout_out_n_in,
	output reg timeout_out_n_out,
	output reg timeout_out_n_oe_out
);
	localparam PIN_IDLE = 2'd0;
	localparam PIN_PULL = 2'd1;
	localparam PIN_HOLD = 2'd2;
	localparam PIN_WAIT = 2'd3;

	wire wr_pulse;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire [7:0] rd_addr;
	reg [31:0] rd_data;
	wire cm_err;

	reg [15:0] div_reg;
	reg tick_reg;
	reg configured_reg;
	reg [1:0] win_sel_reg;
	reg cm_en_reg;
	reg clock_delay_sel_reg;
	reg [15:0] win_cnt_reg;
	reg [15:0] win_cnt_next;
	reg wd_err;
	reg [1:0] pin_state_reg;
	reg [1:0] pin_state_next;
	reg [4:0] hold_cnt_reg;
	reg [4:0] hold_cnt_next;
	reg halt_prev_reg;
	reg idle_prev_reg;
	reg [15:0] idle_timer_reg = 16'h0000;
	reg idle_timer_pending_reg;
	reg svc_cfg;
	reg [1:0] win_sel_next;
	reg cm_en_next;

	wire svc_wr;
	wire [4:0] key;
	wire key_ok;
	wire fields_ok;
	wire halt_exit;
	wire idle_exit;
	wire wd_run;
	wire pin_low;

	// Last instruction cycle of the selected upper limit
	function [15:0] upper_last;
		input [1:0] sel;
		reg [16:0] lim;
		begin
			lim = `UPPER_BASE_TC << sel;
			upper_last = lim[15:0] - 16'h0001;
		end
	endfunction

	axil_reg_port u_bus (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.s_axi_awaddr_in(s_axi_awaddr_in),
		.s_axi_awvalid_in(s_axi_awvalid_in),
		.s_axi_awready_out(s_axi_awready_out),
		.s_axi_wdata_in(s_axi_wdata_in),
		.s_axi_wstrb_in(s_axi_wstrb_in),
		.s_axi_wvalid_in(s_axi_wvalid_in),
		.s_axi_wready_out(s_axi_wready_out),
		.s_axi_bresp_out(s_axi_bresp_out),
		.s_axi_bvalid_out(s_axi_bvalid_out),
		.s_axi_bready_in(s_axi_bready_in),
		.s_axi_araddr_in(s_axi_araddr_in),
		.s_axi_arvalid_in(s_axi_arvalid_in),
		.s_axi_arready_out(s_axi_arready_out),
		.s_axi_rdata_out(s_axi_rdata_out),
		.s_axi_rresp_out(s_axi_rresp_out),
		.s_axi_rvalid_out(s_axi_rvalid_out),
		.s_axi_rready_in(s_axi_rready_in),
		.wr_pulse_out(wr_pulse),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data)
	);

	// monitor watches ticks, which stop in HALT
	// reject time between 100 us and 100 ms
	clk_freq_monitor #(
		.LIMIT_CLKS(CM_LIMIT_CLKS)
	) u_cm (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.enable_in(cm_en_reg),
		.tick_in(tick_reg),
		.err_out(cm_err)
	);

	// Instruction-cycle enable, absent when oscillator stopped
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (!osc_ok_in || halt_in) begin
			tick_reg <= 1'b0;
		end else if (div_reg == CYCLE_DIV - 1) begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b1;
		end else begin
			div_reg <= div_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end

	// Service write decode
	assign key = wr_data[`SVC_KEY_HI:`SVC_KEY_LO];
	assign key_ok = (key == `SVC_KEY);
	assign fields_ok = key_ok &&
		(wr_data[`SVC_WIN_HI:`SVC_WIN_LO] == win_sel_reg) &&
		(wr_data[`SVC_CM_BIT] == cm_en_reg);
	// ignored while the pin is active
	assign svc_wr = wr_pulse && (wr_addr == `OFF_SERVICE) && (pin_state_reg == PIN_IDLE);
	assign halt_exit = halt_prev_reg && !halt_in;
	assign idle_exit = idle_prev_reg && !idle_in;
	// counting stops in HALT, IDLE and while timed out
	assign wd_run = tick_reg && !halt_in && !idle_in && (pin_state_reg == PIN_IDLE);
	assign pin_low = !timeout_out_n_in;

	// Window counter, service checks and configuration
	always @* begin
		win_cnt_next = win_cnt_reg;
		wd_err = 1'b0;
		svc_cfg = 1'b0;
		win_sel_next = win_sel_reg;
		cm_en_next = cm_en_reg;
		if (wd_run)
			win_cnt_next = win_cnt_reg + 16'h0001;
		if (wd_run && win_cnt_reg == upper_last(win_sel_reg))
			wd_err = 1'b1;
		// RC with clock delay clear keeps the count
		// otherwise reload the window after HALT
		if (halt_exit && !(rc_osc_option_in && !clock_delay_sel_reg))
			win_cnt_next = 16'h0000;
		if (idle_exit)
			win_cnt_next = 16'h0000;
		if (svc_wr) begin
			if (!configured_reg) begin
				// no lower check on first service
				if (key_ok) begin
					svc_cfg = 1'b1;
					win_sel_next = wr_data[`SVC_WIN_HI:`SVC_WIN_LO];
					cm_en_next = wr_data[`SVC_CM_BIT];
					win_cnt_next = 16'h0000;
				end else begin
					wd_err = 1'b1;
				end
			end else if (fields_ok && win_cnt_reg >= `LOWER_LIMIT_TC) begin
				win_cnt_next = 16'h0000;
			end else begin
				wd_err = 1'b1;
			end
		end
		if (pin_state_reg == PIN_WAIT && !pin_low)
			win_cnt_next = 16'h0000;
	end

	// reset arms widest window with monitor on
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			configured_reg <= 1'b0;
			win_sel_reg <= `SVC_WIN_RESET;
			cm_en_reg <= `SVC_CM_RESET;
			win_cnt_reg <= 16'h0000;
			halt_prev_reg <= 1'b0;
			idle_prev_reg <= 1'b0;
		end else begin
			if (svc_cfg)
				configured_reg <= 1'b1;
			win_sel_reg <= win_sel_next;
			cm_en_reg <= cm_en_next;
			win_cnt_reg <= win_cnt_next;
			halt_prev_reg <= halt_in;
			idle_prev_reg <= idle_in;
		end
	end

	// Timeout pin sequencing shared by watchdog and monitor
	always @* begin
		pin_state_next = pin_state_reg;
		hold_cnt_next = hold_cnt_reg;
		case (pin_state_reg)
			PIN_IDLE: begin
				// pin low at power-up times out
				if (wd_err || cm_err || pin_low) begin
					pin_state_next = PIN_PULL;
					hold_cnt_next = 5'h00;
				end
			end
			PIN_PULL: begin
				// wait for the sensed low level
				if (pin_low && !cm_err) begin
					pin_state_next = PIN_HOLD;
					hold_cnt_next = 5'h00;
				end
			end
			PIN_HOLD: begin
				if (cm_err) begin
					pin_state_next = PIN_PULL;
				end else if (tick_reg) begin
					if (hold_cnt_reg == `PIN_HOLD_TC - 5'h01)
						pin_state_next = PIN_WAIT;
					else
						hold_cnt_next = hold_cnt_reg + 5'h01;
				end
			end
			PIN_WAIT: begin
				if (cm_err)
					pin_state_next = PIN_PULL;
				else if (!pin_low)
					pin_state_next = PIN_IDLE;
			end
			default: begin
				pin_state_next = PIN_IDLE;
			end
		endcase
	end

	// Pin state and registered drive enable
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			pin_state_reg <= PIN_IDLE;
			hold_cnt_reg <= 5'h00;
			timeout_out_n_out <= 1'b0;
			timeout_out_n_oe_out <= 1'b0;
		end else begin
			pin_state_reg <= pin_state_next;
			hold_cnt_reg <= hold_cnt_next;
			timeout_out_n_out <= 1'b0; // Open drain, only ever pulls low
			timeout_out_n_oe_out <= (pin_state_next == PIN_PULL) || (pin_state_next == PIN_HOLD);
		end
	end

	// idle timer free-runs and is never reset
	always @(posedge clk_in) begin
		if (tick_reg)
			idle_timer_reg <= idle_timer_reg + 16'h0001;
	end

	// pending flag set on bit toggle, cleared by software
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			idle_timer_pending_reg <= 1'b0;
		end else if (tick_reg && idle_timer_reg[`IDLE_PEND_BIT - 1:0] == {`IDLE_PEND_BIT{1'b1}}) begin
			idle_timer_pending_reg <= 1'b1; // Set beats clear
		end else if (wr_pulse && wr_addr == `OFF_STATUS && wr_data[`STS_PEND_BIT]) begin
			idle_timer_pending_reg <= 1'b0;
		end
	end

	// Clock delay control bit
	always @(posedge clk_in) begin
		if (sys_rst_in)
			clock_delay_sel_reg <= 1'b0;
		else if (wr_pulse && wr_addr == `OFF_CONTROL)
			clock_delay_sel_reg <= wr_data[`CTL_CLOCK_DELAY_BIT];
	end

	// Read data multiplexer
	always @* begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
			`OFF_SERVICE: begin
				rd_data[`SVC_WIN_HI:`SVC_WIN_LO] = win_sel_reg;
				rd_data[`SVC_CM_BIT] = cm_en_reg;
			end
			`OFF_CONTROL: begin
				rd_data[`CTL_CLOCK_DELAY_BIT] = clock_delay_sel_reg;
			end
			`OFF_STATUS: begin
				rd_data[`STS_PEND_BIT] = idle_timer_pending_reg;
				rd_data[`STS_ACTIVE_BIT] = (pin_state_reg != PIN_IDLE);
				rd_data[`STS_CMERR_BIT] = cm_err;
				rd_data[`STS_CONFIG_BIT] = configured_reg;
			end
			`OFF_IDLE_TIMER: begin
				rd_data[15:0] = idle_timer_reg;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end
endmodule
`default_nettype wire

// *** sim/wdog_checker_assertions.sv ***
// Concurrent checks on the timeout pin and the register read path
`timescale 1ns/1ps
`default_nettype none
module wdog_checker #(
	parameter CYCLE_DIV = 10,
	parameter CM_LIMIT_CLKS = 25000
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic osc_ok_in,
	input wire logic halt_in,
	input wire logic timeout_out_n_in,
	input wire logic timeout_out_n_out,
	input wire logic timeout_out_n_oe_out
);
	logic [15:0] low_cnt;
	logic [15:0] stop_cnt;
	logic [7:0] rd_addr;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// Pulled cycles with ticks running, cycles without ticks, read address
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			low_cnt <= 16'h0000;
			stop_cnt <= 16'h0000;
			rd_addr <= 8'h00;
		end else begin
			low_cnt <= (timeout_out_n_oe_out && osc_ok_in && !halt_in) ? low_cnt + 16'h0001 : 16'h0000;
			stop_cnt <= (!osc_ok_in || halt_in) ? stop_cnt + 16'h0001 : 16'h0000;
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				rd_addr <= s_axi_araddr_in;
			end
		end
	end
	reset_idle_a: assert property ($fell(sys_rst_in) |-> !timeout_out_n_oe_out)
		else $error("pin pulled right after reset");
	drive_low_a: assert property (timeout_out_n_oe_out |-> !timeout_out_n_out)
		else $error("pin driven high");
	hold_min_a: assert property ($fell(timeout_out_n_oe_out) |-> low_cnt >= 15 * CYCLE_DIV)
		else $error("pin released too soon");
	hold_max_a: assert property (low_cnt <= 33 * CYCLE_DIV + 4)
		else $error("pin held too long");
	monitor_trip_a: assert property (stop_cnt == CM_LIMIT_CLKS + 3 |-> timeout_out_n_oe_out)
		else $error("stopped clock not flagged");
	key_hidden_a: assert property (s_axi_rvalid_out && rd_addr == 8'h00 |-> s_axi_rdata_out[5:1] == 5'h00)
		else $error("key field visible");
	powerup_low_a: assert property ($fell(sys_rst_in) && !timeout_out_n_in |-> ##[1:3] timeout_out_n_oe_out)
		else $error("low pin at reset ignored");
	read_gap_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> !s_axi_rvalid_out ##1 s_axi_rvalid_out)
		else $error("read answer late");
endmodule
bind windowed_watchdog_clock_monitor wdog_checker #(
	.CYCLE_DIV(CYCLE_DIV),
	.CM_LIMIT_CLKS(CM_LIMIT_CLKS)
) chk_u (
	.clk_in(clk_in),
	.sys_rst_in(sys_rst_in),
	.s_axi_araddr_in(s_axi_araddr_in),
	.s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out),
	.s_axi_rdata_out(s_axi_rdata_out),
	.s_axi_rvalid_out(s_axi_rvalid_out),
	.osc_ok_in(osc_ok_in),
	.halt_in(halt_in),
	.timeout_out_n_in(timeout_out_n_in),
	.timeout_out_n_out(timeout_out_n_out),
	.timeout_out_n_oe_out(timeout_out_n_oe_out)
);
`default_nettype wire

// *** sim/pin_pullup_model.sv ***
// Pull-up resistor and outside load on the open-drain timeout pin
`timescale 1ns/1ps
`default_nettype none
module pin_pullup_model (
	input wire logic clk_in,
	input wire logic oe_in,
	input wire logic drive_in,
	input wire logic hold_low_in,
	input wire logic slow_in,
	output logic level_out
);
	logic [2:0] lag = 3'h0;
	// Slow RC rise keeps the pin low a few cycles after release
	always @(posedge clk_in) begin
		lag <= oe_in ? 3'h5 : (lag != 3'h0 ? lag - 3'h1 : 3'h0);
	end
	// high once released, unless held low outside or still low during the slow rise
	assign level_out = !((oe_in && !drive_in) || hold_low_in || (slow_in && lag != 3'h0));
endmodule
`default_nettype wire

// *** sim/windowed_watchdog_clock_monitor_tb.sv ***
// Self-checking bench for the windowed watchdog with clock monitor
`timescale 1ns/1ps
`default_nettype none
`include "wdog_consts.vh"
module windowed_watchdog_clock_monitor_tb;
	localparam int DIV = 2;
	localparam int CM = 200;
	localparam int HOLD = 16 * DIV;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic osc_ok = 1'b1, halt = 1'b0, idle = 1'b0, hold_low = 1'b0, slow = 1'b0, rc_opt = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid, oe, pin_drv, pin;
	wire logic [1:0] bresp;
	wire logic [1:0] rresp;
	wire logic [31:0] rdata;
	logic [31:0] rv, got, stamp;
	logic [1:0] resp;
	int bad_count = 0;
	int check_count = 0;
	int n;
	windowed_watchdog_clock_monitor #(.CYCLE_DIV(DIV), .CM_LIMIT_CLKS(CM)) dut_u (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hf),
		.s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready),
		.osc_ok_in(osc_ok),
		.halt_in(halt),
		.idle_in(idle),
		.rc_osc_option_in(rc_opt),
		.timeout_out_n_in(pin),
		.timeout_out_n_out(pin_drv),
		.timeout_out_n_oe_out(oe)
	);
	pin_pullup_model pull_u (
		.clk_in(clk_in),
		.oe_in(oe),
		.drive_in(pin_drv),
		.hold_low_in(hold_low),
		.slow_in(slow),
		.level_out(pin)
	);
	// Free-running system clock
	always #20 clk_in = ~clk_in;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Service byte with one field spoiled
	function automatic logic [7:0] spoil(input int k, input logic [31:0] r);
		if (k == 0) return 8'h19 ^ {2'h0, (r[4:0] % 5'h1f) + 5'h01, 1'b0};
		if (k == 1) return 8'h19 ^ {(r[1:0] % 2'h3) + 2'h1, 6'h00};
		return 8'h18;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic hung;
		chk(32'h0000_0000, 32'h0000_0001);
		summarize();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		n = 0;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		bready <= 1'b0;
		resp = bresp;
		if (n >= 50) hung();
	endtask
	task automatic rd(input logic [7:0] a);
		n = 0;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		rready <= 1'b0;
		got = rdata;
		resp = rresp;
		if (n >= 50) hung();
	endtask
	task automatic wait_oe(input logic v, input int lim);
		n = 0;
		while (oe !== v && n < lim) begin
			@(posedge clk_in);
			n++;
		end
		if (n >= lim) hung();
	endtask
	// Expect an error, optionally write meanwhile, then let the pin go
	task automatic trip(input logic w);
		wait_oe(1'b1, 20);
		rv = xs(rv);
		slow <= rv[0];
		if (w) wr(`OFF_SERVICE, 8'h19);
		wait_oe(1'b0, 4 * HOLD);
		chk(n <= 2 * HOLD + 4 && (w || n >= HOLD - DIV), 1'b1);
		repeat (4200) @(posedge clk_in);
	endtask
	initial begin
		rv = 32'd17;
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rd(`OFF_SERVICE);
		chk(got, 32'h0000_00C1);
		wr(`OFF_SERVICE, 8'h19);
		repeat (20) @(posedge clk_in);
		chk(oe, 1'b0);
		rd(`OFF_SERVICE);
		chk(got, 32'h0000_0001);
		wr(`OFF_SERVICE, 8'h19);
		trip(1'b1);
		wr(`OFF_SERVICE, 8'h19);
		repeat (20) @(posedge clk_in);
		chk(oe, 1'b0);
		repeat (4200) @(posedge clk_in);
		for (int k = 0; k < 3; k++) begin
			rv = xs(rv);
			wr(`OFF_SERVICE, spoil(k, rv));
			trip(1'b0);
		end
		rd(`OFF_SERVICE);
		chk(got, 32'h0000_0001);
		wr(`OFF_SERVICE, 8'h19);
		wait_oe(1'b1, 17000);
		chk(n >= 8192 * DIV - 3 * DIV && n <= 8192 * DIV + 3 * DIV, 1'b1);
		trip(1'b0);
		wr(`OFF_SERVICE, 8'h19);
		idle <= 1'b1;
		repeat (17000) @(posedge clk_in);
		chk(oe, 1'b0);
		idle <= 1'b0;
		wr(`OFF_SERVICE, 8'h19);
		trip(1'b0);
		for (int k = 0; k < 2; k++) begin
			// Short halt below the monitor limit, then service at once
			rc_opt <= (k == 0);
			halt <= 1'b1;
			repeat (50) @(posedge clk_in);
			halt <= 1'b0;
			wr(`OFF_SERVICE, 8'h19);
			if (k == 0) begin
				repeat (20) @(posedge clk_in);
				chk(oe, 1'b0);
				repeat (4200) @(posedge clk_in);
			end else begin
				trip(1'b0);
			end
		end
		for (int k = 0; k < 2; k++) begin
			// stop the oscillator, then enter halt
			if (k == 0) osc_ok <= 1'b0;
			else halt <= 1'b1;
			repeat (CM + 4 * DIV) @(posedge clk_in);
			chk(oe, 1'b1);
			osc_ok <= 1'b1;
			halt <= 1'b0;
			wait_oe(1'b0, 4 * HOLD);
			chk(n >= HOLD - DIV, 1'b1);
			repeat (4200) @(posedge clk_in);
		end
		rd(`OFF_STATUS);
		chk(got[`STS_PEND_BIT], 1'b1);
		wr(`OFF_STATUS, 8'h01);
		rd(`OFF_STATUS);
		chk(got[`STS_PEND_BIT], 1'b0);
		wr(`OFF_CONTROL, 8'h01);
		rd(`OFF_CONTROL);
		chk(got, 32'h0000_0001);
		rd(8'h10);
		chk(resp, `RESP_SLVERR);
		chk(got, 32'h0000_0000);
		wr(8'h10, 8'h19);
		chk(resp, `RESP_SLVERR);
		rd(`OFF_IDLE_TIMER);
		stamp = got;
		hold_low <= 1'b1;
		sys_rst_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		wait_oe(1'b1, 20);
		wr(`OFF_SERVICE, 8'h59);
		hold_low <= 1'b0;
		wait_oe(1'b0, 4 * HOLD);
		rd(`OFF_IDLE_TIMER);
		chk(got[15:0] > stamp[15:0], 1'b1);
		rd(`OFF_SERVICE);
		chk(got, 32'h0000_00C1);
		wr(`OFF_SERVICE, 8'h1B);
		wait_oe(1'b1, 20);
		summarize();
	end
endmodule
`default_nettype wire
